// [core/external_bus_wait_state_control.sv]
`timescale 1ns/1ps
`include "ebw_map.svh"
module external_bus_wait_state_control
#(
	parameter int HAS_XPA  = 1,
	parameter int HAS_MULT = 1
)
(
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [3:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            reqValid,
	output logic                 reqReady,
	input  wire ebw_pkg::space_t reqSpace,
	input  wire logic            reqWrite,
	input  wire logic [15:0]     reqAddr,
	input  wire logic [15:0]     reqWdata,
	output logic                 respValid,
	output logic      [15:0]     respRdata,
	input  wire logic            setFlagInstr,
	input  wire logic            clearFlagInstr,
	input  wire logic            loadStatusOne,
	output logic      [15:0]     extAddr,
	input  wire logic [15:0]     dataIn,
	output logic      [15:0]     dataOut,
	output logic                 dataOe,
	output logic                 dataKeepEn,
	output logic                 ioSpaceStrobeN,
	output logic                 progStrobeN,
	output logic                 dataStrobeN,
	output logic                 xferRead,
	input  wire logic            readyIn,
	output logic                 microstateDoneN,
	output logic                 externalFlagOut
);
	import ebw_pkg::*;

	// Refuse parameter values the logic cannot serve
	if (HAS_XPA < 0 || HAS_XPA > 1)
	begin : g_bad_xpa
		$error("HAS_XPA must be 0 or 1");
	end
	if (HAS_MULT < 0 || HAS_MULT > 1)
	begin : g_bad_mult
		$error("HAS_MULT must be 0 or 1");
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	logic [15:0] waitState_ff;
	logic [15:0] bankSwitch_ff;
	logic        waitMult_ff;
	logic        ackOut_ff;
	logic [31:0] rdData_ff;
	logic        readyMeta_ff;
	logic        readySync2_ff;
	logic        readySync3_ff;
	logic        readyLvl_ff;
	bus_state_t  state_ff;
	logic [3:0]  waitIdx_ff;
	logic [3:0]  waitTotal_ff;
	logic [2:0]  accField_ff;
	logic        accMult_ff;
	logic        readyChk_ff;
	space_t      accSpace_ff;
	logic        accWrite_ff;
	logic [15:0] accAddr_ff;
	logic [15:0] accWdata_ff;
	logic [15:0] extAddr_ff;
	logic [15:0] dataOut_ff;
	logic        dataOe_ff;
	logic        ioStrobeN_ff;
	logic        progStrobeN_ff;
	logic        dataStrobeN_ff;
	logic        xferRead_ff;
	logic        msDoneN_ff;
	logic        flag_ff;
	logic        reqReady_ff;
	logic        respValid_ff;
	logic [15:0] respRdata_ff;
	logic        prevValid_ff;
	logic        prevRead_ff;
	space_t      prevSpace_ff;
	logic [3:0]  prevBank_ff;

	// Scale a 3-bit field by the optional multiplier
	function automatic logic [3:0] scaleWait(input logic [2:0] field, input logic mult);
		scaleWait = mult ? {field, 1'b0} : {1'b0, field};
	endfunction

	// Pick the 3-bit field of the addressed block
	function automatic logic [2:0] blockField(input logic [15:0] wsr, input space_t sp,
		input logic [15:0] addr, input logic extended_prog_addressing);
		logic hi;
		hi = addr[15];
		blockField = wsr[`EBW_PROG_LO_LSB +: 3];
		unique case (sp)
			SPACE_IO:   blockField = wsr[`EBW_IO_LSB +: 3];
			SPACE_DATA: blockField = hi ? wsr[`EBW_DATA_HI_LSB +: 3] : wsr[`EBW_DATA_LO_LSB +: 3];
			SPACE_PROG: blockField = (hi || extended_prog_addressing) ? wsr[`EBW_PROG_HI_LSB +: 3]
				: wsr[`EBW_PROG_LO_LSB +: 3];
		endcase
	endfunction

	logic        wbReq;
	logic        take;
	logic        xpaOn;
	logic        multOn;
	logic [2:0]  reqField;
	logic [3:0]  reqBank;
	logic        progDataSwap;
	logic        needTurn;
	logic        enterAcc;
	logic        lastWait;
	logic        endNow;
	logic [15:0] bankWrMasked;

	// Request decode and turnaround decision
	assign wbReq        = wb_cyc_i && wb_stb_i && !ackOut_ff;
	assign take         = (state_ff == ST_IDLE) && reqValid && reqReady_ff;
	assign xpaOn        = (HAS_XPA == 1) && waitState_ff[`EBW_XPA_BIT];
	assign multOn       = (HAS_MULT == 1) && waitMult_ff;
	assign reqField     = blockField(waitState_ff, reqSpace, reqAddr, xpaOn);
	assign reqBank      = reqAddr[15:12] & bankSwitch_ff[`EBW_BANK_CMP_MSB:`EBW_BANK_CMP_LSB];
	assign progDataSwap = (reqSpace != SPACE_IO) && (prevSpace_ff != SPACE_IO)
		&& (reqSpace != prevSpace_ff);
	assign needTurn     = prevValid_ff && prevRead_ff && !reqWrite
		&& ((bankSwitch_ff[`EBW_TURN_BIT] && progDataSwap) || (reqBank != prevBank_ff));
	assign bankWrMasked = wb_dat_i[15:0] & `EBW_BANK_SWITCH_WMASK;
	assign enterAcc     = (take && !needTurn) || (state_ff == ST_TURN);
	assign lastWait     = (state_ff == ST_WAIT) && (waitIdx_ff == waitTotal_ff);
	assign endNow       = ((state_ff == ST_ACC) && (waitTotal_ff == 4'h0))
		|| (lastWait && (!readyChk_ff || readyLvl_ff))
		|| ((state_ff == ST_RDY) && readyLvl_ff);

	// Register writes with byte lanes, landing at the edge that sees ack high
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			waitState_ff  <= `EBW_WAIT_STATE_RST;
			bankSwitch_ff <= `EBW_BANK_SWITCH_RST;
			waitMult_ff   <= 1'(`EBW_WAIT_CTRL_RST);
		end
		else if (wb_cyc_i && wb_stb_i && wb_we_i && ackOut_ff)
		begin
			unique case (wb_adr_i)
				`EBW_WAIT_STATE_OFS:
				begin
					if (wb_sel_i[0]) waitState_ff[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) waitState_ff[15:8] <= wb_dat_i[15:8];
				end
				`EBW_BANK_SWITCH_OFS:
				begin
					if (wb_sel_i[0])
						bankSwitch_ff[7:0] <= bankWrMasked[7:0];
					if (wb_sel_i[1])
						bankSwitch_ff[15:8] <= bankWrMasked[15:8];
				end
				`EBW_WAIT_CTRL_OFS:
				begin
					if (wb_sel_i[0]) waitMult_ff <= wb_dat_i[`EBW_MULT_BIT];
				end
				default: ;
			endcase
		end
	end

	// Read data and single-cycle acknowledge
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ackOut_ff <= 1'b0;
			rdData_ff <= 32'h0000_0000;
		end
		else
		begin
			ackOut_ff <= wbReq;
			rdData_ff <= 32'h0000_0000;
			if (wbReq && !wb_we_i)
			begin
				unique case (wb_adr_i)
					`EBW_WAIT_STATE_OFS:
						rdData_ff[15:0] <= {xpaOn, waitState_ff[14:0]};
					`EBW_BANK_SWITCH_OFS:  rdData_ff[15:0] <= bankSwitch_ff;
					`EBW_WAIT_CTRL_OFS:    rdData_ff[0] <= multOn;
					`EBW_STATUS_OFS:
						rdData_ff[3:0] <= {flag_ff, msDoneN_ff, readyLvl_ff,
							state_ff != ST_IDLE};
					default: ;
				endcase
			end
		end
	end

	// Ready pin synchroniser; level changes once stages two and three agree
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			readyMeta_ff  <= 1'b1;
			readySync2_ff <= 1'b1;
			readySync3_ff <= 1'b1;
			readyLvl_ff   <= 1'b1;
		end
		else
		begin
			readyMeta_ff  <= readyIn;
			readySync2_ff <= readyMeta_ff;
			readySync3_ff <= readySync2_ff;
			if (readySync2_ff == readySync3_ff)
				readyLvl_ff <= readySync3_ff;
		end
	end

	// Access sequencer
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state_ff     <= ST_IDLE;
			waitIdx_ff   <= 4'h0;
			waitTotal_ff <= 4'h0;
			accField_ff  <= 3'h0;
			accMult_ff   <= 1'b0;
			readyChk_ff  <= 1'b0;
			accSpace_ff  <= SPACE_PROG;
			accWrite_ff  <= 1'b0;
			accAddr_ff   <= 16'h0000;
			accWdata_ff  <= 16'h0000;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					if (take)
					begin
						accField_ff  <= reqField;
						accMult_ff   <= multOn;
						waitTotal_ff <= scaleWait(reqField, multOn);
						readyChk_ff  <= scaleWait(reqField, multOn) >= `EBW_READY_MIN_WAITS;
						accSpace_ff  <= reqSpace;
						accWrite_ff  <= reqWrite;
						accAddr_ff   <= reqAddr;
						accWdata_ff  <= reqWdata;
						state_ff     <= needTurn ? ST_TURN : ST_ACC;
					end
				end
				ST_TURN: state_ff <= ST_ACC;
				ST_ACC:
				begin
					waitIdx_ff <= 4'h1;
					state_ff   <= endNow ? ST_END : ST_WAIT;
				end
				ST_WAIT:
				begin
					waitIdx_ff <= 4'(waitIdx_ff + 4'h1);
					if (lastWait)
						state_ff <= endNow ? ST_END : ST_RDY;
				end
				ST_RDY:
				begin
					if (endNow)
						state_ff <= ST_END;
				end
				ST_END: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Pin drive held for the whole stretched access
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			extAddr_ff     <= 16'h0000;
			dataOut_ff     <= 16'h0000;
			dataOe_ff      <= 1'b0;
			ioStrobeN_ff   <= 1'b1;
			progStrobeN_ff <= 1'b1;
			dataStrobeN_ff <= 1'b1;
			xferRead_ff    <= 1'b1;
		end
		else if (enterAcc)
		begin
			extAddr_ff     <= (state_ff == ST_TURN) ? accAddr_ff : reqAddr;
			if ((state_ff == ST_TURN) ? accWrite_ff : reqWrite)
			begin
				xferRead_ff <= 1'b0;
				dataOe_ff   <= 1'b1;
				dataOut_ff  <= (state_ff == ST_TURN) ? accWdata_ff : reqWdata;
			end
			ioStrobeN_ff   <= ((state_ff == ST_TURN) ? accSpace_ff : reqSpace) != SPACE_IO;
			progStrobeN_ff <= ((state_ff == ST_TURN) ? accSpace_ff : reqSpace) != SPACE_PROG;
			dataStrobeN_ff <= ((state_ff == ST_TURN) ? accSpace_ff : reqSpace) != SPACE_DATA;
		end
		else if (endNow)
		begin
			ioStrobeN_ff   <= 1'b1;
			progStrobeN_ff <= 1'b1;
			dataStrobeN_ff <= 1'b1;
			xferRead_ff    <= 1'b1;
			dataOe_ff      <= 1'b0;
			if (!accWrite_ff && bankSwitch_ff[`EBW_KEEP_BIT])
				dataOut_ff <= dataIn;
		end
	end

	// Microstate-complete output
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			msDoneN_ff <= 1'b1;
		else if ((state_ff == ST_ACC) && !endNow && (waitTotal_ff >= 4'h2))
			msDoneN_ff <= 1'b0;
		else if ((state_ff == ST_WAIT) && (4'(waitIdx_ff + 4'h1) == waitTotal_ff))
			msDoneN_ff <= 1'b1;
	end

	// Request acceptance, completion and turnaround history
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			reqReady_ff  <= 1'b0;
			respValid_ff <= 1'b0;
			respRdata_ff <= 16'h0000;
			prevValid_ff <= 1'b0;
			prevRead_ff  <= 1'b0;
			prevSpace_ff <= SPACE_PROG;
			prevBank_ff  <= 4'h0;
		end
		else
		begin
			reqReady_ff  <= ((state_ff == ST_END) || ((state_ff == ST_IDLE) && !take))
				&& !bankSwitch_ff[`EBW_BUS_OFF_BIT];
			respValid_ff <= endNow;
			if (endNow)
			begin
				respRdata_ff <= accWrite_ff ? 16'h0000 : dataIn;
				prevValid_ff <= 1'b1;
				prevRead_ff  <= !accWrite_ff;
				prevSpace_ff <= accSpace_ff;
				prevBank_ff  <= accAddr_ff[15:12]
					& bankSwitch_ff[`EBW_BANK_CMP_MSB:`EBW_BANK_CMP_LSB];
			end
		end
	end

	// Latched external flag; set wins if both arrive together
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			flag_ff <= 1'b0;
		else if (setFlagInstr)
			flag_ff <= 1'b1;
		else if (clearFlagInstr || loadStatusOne)
			flag_ff <= 1'b0;
	end

	assign wb_dat_o        = rdData_ff;
	assign wb_ack_o        = ackOut_ff;
	assign reqReady        = reqReady_ff;
	assign respValid       = respValid_ff;
	assign respRdata       = respRdata_ff;
	assign extAddr         = extAddr_ff;
	assign dataOut         = dataOut_ff;
	assign dataOe          = dataOe_ff;
	assign dataKeepEn      = bankSwitch_ff[`EBW_KEEP_BIT];
	assign ioSpaceStrobeN  = ioStrobeN_ff;
	assign progStrobeN     = progStrobeN_ff;
	assign dataStrobeN     = dataStrobeN_ff;
	assign xferRead        = xferRead_ff;
	assign microstateDoneN = msDoneN_ff;
	assign externalFlagOut = flag_ff;

	// Checks on the sequencer and pins
	io_strobe_a: assert property (!ioStrobeN_ff |-> accSpace_ff == SPACE_IO
		&& (state_ff == ST_ACC || state_ff == ST_WAIT || state_ff == ST_RDY))
		else $error("I/O strobe low outside an I/O access");
	dir_write_a: assert property (!xferRead_ff |-> accWrite_ff && dataOe_ff)
		else $error("Direction low without a write");
	ready_retry_a: assert property (state_ff == ST_RDY && !readyLvl_ff |=> state_ff == ST_RDY)
		else $error("Access ended while ready low");
	ready_gate_a: assert property (state_ff == ST_RDY |-> waitTotal_ff >= 4'h2)
		else $error("Ready checked with fewer than two waits");
	ready_late_a: assert property (state_ff == ST_WAIT && waitIdx_ff < waitTotal_ff
		|=> state_ff == ST_WAIT && waitIdx_ff == $past(waitIdx_ff) + 4'h1)
		else $error("Software waits cut short");
	ms_fall_a: assert property ($fell(msDoneN_ff) |-> state_ff == ST_WAIT
		&& waitIdx_ff == 4'h1 && waitTotal_ff >= 4'h2)
		else $error("Microstate fell off the first wait");
	ms_rise_a: assert property ($rose(msDoneN_ff) |-> state_ff == ST_WAIT
		&& waitIdx_ff == waitTotal_ff)
		else $error("Microstate rose off the last wait");
	flag_set_a: assert property (setFlagInstr |=> flag_ff)
		else $error("Flag not set");
	flag_clr_a: assert property ((clearFlagInstr || loadStatusOne) && !setFlagInstr
		|=> !flag_ff)
		else $error("Flag not cleared");
	zero_wait_a: assert property (state_ff == ST_ACC && waitTotal_ff == 4'h0
		|=> state_ff == ST_END ##1 state_ff == ST_IDLE)
		else $error("Zero-wait access stretched");
	wait_scale_a: assert property (state_ff == ST_ACC |-> waitTotal_ff
		== (accMult_ff ? {accField_ff, 1'b0} : {1'b0, accField_ff}))
		else $error("Wait count not scaled");
	bus_off_a: assert property (bankSwitch_ff[`EBW_BUS_OFF_BIT] |=> !reqReady_ff)
		else $error("Request taken with bus off");
	stable_pins_a: assert property (state_ff == ST_WAIT || state_ff == ST_RDY
		|-> $stable(extAddr_ff) && $stable(xferRead_ff) && $stable(ioStrobeN_ff))
		else $error("Pins moved during an access");
	turn_gap_a: assert property (state_ff == ST_TURN |-> ioStrobeN_ff && progStrobeN_ff
		&& dataStrobeN_ff)
		else $error("Strobe active in turnaround");

endmodule

// [core/ebw_map.svh]
`ifndef EBW_MAP_SVH
`define EBW_MAP_SVH

// Register byte offsets on the Wishbone slave
`define EBW_WAIT_STATE_OFS   4'h0
`define EBW_BANK_SWITCH_OFS  4'h4
`define EBW_WAIT_CTRL_OFS    4'h8
`define EBW_STATUS_OFS       4'hc

// Reset values
`define EBW_WAIT_STATE_RST   16'h7fff
`define EBW_BANK_SWITCH_RST  16'h0000
`define EBW_WAIT_CTRL_RST    16'h0000

// Wait-state register field positions (3-bit fields)
`define EBW_XPA_BIT          15
`define EBW_IO_LSB           12
`define EBW_DATA_HI_LSB      9
`define EBW_DATA_LO_LSB      6
`define EBW_PROG_HI_LSB      3
`define EBW_PROG_LO_LSB      0

// Bank-switch register field positions
`define EBW_BANK_CMP_MSB     15
`define EBW_BANK_CMP_LSB     12
`define EBW_TURN_BIT         11
`define EBW_KEEP_BIT         1
`define EBW_BUS_OFF_BIT      0
`define EBW_BANK_SWITCH_WMASK 16'hf803

// Wait control register
`define EBW_MULT_BIT         0

// Timing counts
`define EBW_READY_MIN_WAITS  4'h2
`define EBW_MAX_FIELD        3'h7

`endif

// [core/ebw_pkg.sv]
package ebw_pkg;

	// Address space of a bus access
	typedef enum logic [1:0] {SPACE_PROG, SPACE_DATA, SPACE_IO} space_t;

	// External bus sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_ACC, ST_WAIT, ST_RDY, ST_END} bus_state_t;

endpackage

// [testbench/ebw_slow_peripheral.sv]
`timescale 1ns/1ps
module ebw_slow_peripheral
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] extAddr,
	input  wire logic [15:0] dataOut,
	input  wire logic        dataOe,
	input  wire logic        ioSpaceStrobeN,
	input  wire logic        progStrobeN,
	input  wire logic        dataStrobeN,
	input  wire logic        xferRead,
	input  wire logic [3:0]  slowCycles,
	output logic      [15:0] dataIn,
	output logic             readyIn
);
	logic [15:0] mem [16];
	logic [15:0] lastBus;
	logic [3:0]  busyCnt;
	logic        memSel;
	logic        ioReadStrobeN;
	logic        ioWriteStrobeN;
	initial
	begin
		lastBus = 16'h5a5a;
		foreach (mem[i])
			mem[i] = 16'h0000;
	end
	// Board glue splits the I/O strobe by direction
	assign ioReadStrobeN  = ioSpaceStrobeN || !xferRead;
	assign ioWriteStrobeN = ioSpaceStrobeN || xferRead;
	assign memSel         = !progStrobeN || !dataStrobeN;
	// Unselected bus shows a changing pattern, never the last value
	assign dataIn  = (!ioReadStrobeN || (memSel && xferRead)) ? mem[extAddr[3:0]] : ~lastBus;
	// Ready low while idle and for slowCycles of an access when slowCycles is nonzero, past the last software wait
	assign readyIn = busyCnt >= slowCycles;
	// Access length counter and write capture
	always_ff @(posedge sys_clk)
	begin
		if (ioSpaceStrobeN && !memSel)
			busyCnt <= 4'h0;
		else if (busyCnt != 4'hf)
			busyCnt <= busyCnt + 4'h1;
		lastBus <= dataIn;
		if (dataOe && (!ioWriteStrobeN || (memSel && !xferRead)))
			mem[extAddr[3:0]] <= dataOut;
	end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
	import ebw_pkg::*;
	logic        sys_clk;
	logic        reset_n;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [3:0]  wb_adr_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        reqValid;
	logic        reqReady;
	space_t      reqSpace;
	logic        reqWrite;
	logic [15:0] reqAddr;
	logic [15:0] reqWdata;
	logic        respValid;
	logic [15:0] respRdata;
	logic [2:0]  flagCmd;
	logic [15:0] extAddr;
	logic [15:0] dataIn;
	logic [15:0] dataOut;
	logic        dataOe;
	logic        dataKeepEn;
	logic        ioSpaceStrobeN;
	logic        progStrobeN;
	logic        dataStrobeN;
	logic        xferRead;
	logic        readyIn;
	logic        microstateDoneN;
	logic        externalFlagOut;
	logic [3:0]  slowCycles;
	int          fails;
	int          samplesChecked;
	external_bus_wait_state_control i_external_bus_wait_state_control (
		.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reqValid(reqValid), .reqReady(reqReady),
		.reqSpace(reqSpace), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.respValid(respValid), .respRdata(respRdata), .setFlagInstr(flagCmd[2]),
		.clearFlagInstr(flagCmd[1]), .loadStatusOne(flagCmd[0]), .extAddr(extAddr),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .dataKeepEn(dataKeepEn),
		.ioSpaceStrobeN(ioSpaceStrobeN), .progStrobeN(progStrobeN),
		.dataStrobeN(dataStrobeN), .xferRead(xferRead), .readyIn(readyIn),
		.microstateDoneN(microstateDoneN), .externalFlagOut(externalFlagOut));
	ebw_slow_peripheral i_ebw_slow_peripheral (
		.sys_clk(sys_clk), .extAddr(extAddr), .dataOut(dataOut), .dataOe(dataOe),
		.ioSpaceStrobeN(ioSpaceStrobeN), .progStrobeN(progStrobeN),
		.dataStrobeN(dataStrobeN), .xferRead(xferRead), .slowCycles(slowCycles),
		.dataIn(dataIn), .readyIn(readyIn));
	initial
	begin
		sys_clk = 1'b0;
		forever
			#12.5 sys_clk = ~sys_clk;
	end
	task automatic completeRun;
		$display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkCount(input int got, input int exp);
		samplesChecked++;
		if (got != exp)
		begin
			fails++;
			$display("Error at %0t: cycles %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle, waits for ack, one idle cycle after
	task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		do
			@(posedge sys_clk);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask
	// One core access; returns cycles from take to completion and microstate-low cycles
	task automatic access(input space_t sp, input logic wr, input logic [15:0] adr,
		input logic [15:0] wd, output logic [15:0] rd, output int cyc, output int msLow);
		logic        ioLast;
		logic        rwLast;
		logic [15:0] adrLast;
		reqValid <= 1'b1;
		reqSpace <= sp;
		reqWrite <= wr;
		reqAddr  <= adr;
		reqWdata <= wd;
		do
			@(negedge sys_clk);
		while (reqReady !== 1'b1);
		@(posedge sys_clk);
		reqValid <= 1'b0;
		cyc = 0;
		msLow = 0;
		forever
		begin
			@(negedge sys_clk);
			cyc++;
			if (respValid === 1'b1)
				break;
			ioLast = ioSpaceStrobeN;
			rwLast = xferRead;
			adrLast = extAddr;
			msLow += (microstateDoneN === 1'b0);
		end
		rd = respRdata;
		checkVal(ioLast, sp != SPACE_IO);
		checkVal(rwLast, !wr);
		checkVal(adrLast, adr);
		checkVal({ioSpaceStrobeN, xferRead}, 2'b11);
		@(posedge sys_clk);
	endtask
	task automatic flagPulse(input logic [2:0] p, input logic exp);
		flagCmd <= p;
		@(posedge sys_clk);
		flagCmd <= 3'h0;
		@(negedge sys_clk);
		checkVal(externalFlagOut, exp);
		@(posedge sys_clk);
	endtask
	// Whole run needs about 300 cycles; allow fifty times that
	initial
	begin
		repeat (15000) @(posedge sys_clk);
		fails++;
		completeRun();
	end
	// Main sequence
	initial
	begin
		logic [31:0] r;
		logic [15:0] d;
		int          c;
		int          m;
		int          n;
		space_t      sps [5];
		logic [15:0] ads [5];
		logic [2:0]  fld [5];
		sps = '{SPACE_PROG, SPACE_PROG, SPACE_DATA, SPACE_DATA, SPACE_IO};
		ads = '{16'h0001, 16'h8002, 16'h0003, 16'h8004, 16'h0005};
		fld = '{3'h1, 3'h7, 3'h0, 3'h3, 3'h5};
		{wb_cyc_i, wb_stb_i, wb_we_i, reqValid, reqWrite} = 5'h00;
		{wb_adr_i, wb_dat_i, reqAddr, reqWdata} = 68'h0;
		reqSpace = SPACE_PROG;
		flagCmd = 3'h0;
		slowCycles = 4'h0;
		fails = 0;
		samplesChecked = 0;
		reset_n = 1'b0;
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		wbXfer(1'b0, 4'h0, 32'h0, r);
		checkVal(r, 32'h7fff);
		wbXfer(1'b0, 4'h4, 32'h0, r);
		checkVal(r, 32'h0);
		wbXfer(1'b0, 4'h2, 32'h0, r);
		checkVal(r, 32'h0);
		$display("Register reset test done");
		for (int k = 0; k < 2; k++)
		begin
			wbXfer(1'b1, 4'h8, k, r);
			wbXfer(1'b1, 4'h0, {17'h0, fld[4], fld[3], fld[2], fld[1], fld[0]}, r);
			for (int i = 0; i < 5; i++)
			begin
				n = fld[i] << k;
				access(sps[i], 1'b1, ads[i], ads[i] ^ 16'ha5c3, d, c, m);
				checkCount(c, n + 2);
				checkCount(m, (n >= 2) ? n - 1 : 0);
				access(sps[i], 1'b0, ads[i], 16'h0, d, c, m);
				checkCount(c, n + 2);
				checkVal(d, ads[i] ^ 16'ha5c3);
			end
		end
		$display("Wait-state table test done");
		wbXfer(1'b1, 4'h8, 32'h0, r);
		wbXfer(1'b1, 4'h0, 32'h8038, r);
		access(SPACE_PROG, 1'b0, 16'h0001, 16'h0, d, c, m);
		checkCount(c, 9);
		slowCycles <= 4'h8;
		wbXfer(1'b1, 4'h0, 32'h1000, r);
		access(SPACE_IO, 1'b0, 16'h0005, 16'h0, d, c, m);
		checkCount(c, 3);
		wbXfer(1'b1, 4'h0, 32'h2000, r);
		access(SPACE_IO, 1'b0, 16'h0005, 16'h0, d, c, m);
		checkVal(c > 10, 1'b1);
		checkVal(d, 16'h0005 ^ 16'ha5c3);
		slowCycles <= 4'h0;
		$display("Ready test done");
		wbXfer(1'b1, 4'h0, 32'h0, r);
		wbXfer(1'b1, 4'h4, 32'h0800, r);
		access(SPACE_PROG, 1'b0, 16'h0001, 16'h0, d, c, m);
		access(SPACE_DATA, 1'b0, 16'h0003, 16'h0, d, c, m);
		checkCount(c, 3);
		access(SPACE_DATA, 1'b0, 16'h0003, 16'h0, d, c, m);
		checkCount(c, 2);
		wbXfer(1'b1, 4'h4, 32'hf000, r);
		access(SPACE_DATA, 1'b0, 16'h1003, 16'h0, d, c, m);
		checkCount(c, 3);
		access(SPACE_DATA, 1'b0, 16'h1003, 16'h0, d, c, m);
		checkCount(c, 2);
		wbXfer(1'b1, 4'h4, 32'h0002, r);
		access(SPACE_DATA, 1'b0, 16'h0003, 16'h0, d, c, m);
		checkVal({dataOe, dataOut}, {1'b0, 16'h0003 ^ 16'ha5c3});
		$display("Turnaround test done");
		wbXfer(1'b1, 4'h4, 32'hffff, r);
		wbXfer(1'b0, 4'h4, 32'h0, r);
		checkVal(r, 32'hf803);
		@(negedge sys_clk);
		checkVal({dataKeepEn, reqReady}, 2'b10);
		@(posedge sys_clk);
		wbXfer(1'b1, 4'h4, 32'h0, r);
		@(negedge sys_clk);
		checkVal({dataKeepEn, reqReady}, 2'b01);
		@(posedge sys_clk);
		$display("Bus control test done");
		flagPulse(3'h4, 1'b1);
		flagPulse(3'h2, 1'b0);
		flagPulse(3'h4, 1'b1);
		flagPulse(3'h0, 1'b1);
		flagPulse(3'h1, 1'b0);
		flagPulse(3'h6, 1'b1);
		$display("Flag test done");
		completeRun();
	end
endmodule
